// >>> crb_pkg.sv
package crb_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int XW    = 60;
    localparam int AW    = 18;
    localparam int BW    = 21;
    localparam int ELW   = 24;
    localparam int EMW   = 6;
    localparam int PARW  = 15;
    localparam int NPAR  = 4;
    localparam int EZB   = 6;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [5:0] OP_STOP = 6'h00;
    localparam logic [5:0] OP_RET  = 6'h01;
    localparam logic [5:0] OP_JMP  = 6'h02;
    localparam logic [5:0] OP_XBR  = 6'h03;
    localparam logic [5:0] OP_BEQ  = 6'h04;
    localparam logic [5:0] OP_BNE  = 6'h05;
    localparam logic [5:0] OP_BGE  = 6'h06;
    localparam logic [5:0] OP_BLT  = 6'h07;
    localparam logic [2:0] SUB_RJ  = 3'h0;
    localparam logic [2:0] SUB_XJ  = 3'h3;

    // ----------------------------------------
    // swap package layout
    // ----------------------------------------
    localparam logic [2:0] PKG_P     = 3'h0;
    localparam logic [2:0] PKG_BASE  = 3'h1;
    localparam logic [2:0] PKG_LIM   = 3'h2;
    localparam logic [2:0] PKG_EM    = 3'h3;
    localparam logic [2:0] PKG_EBASE = 3'h4;
    localparam logic [2:0] PKG_ELIM  = 3'h5;
    localparam logic [2:0] PKG_MON   = 3'h6;
    localparam int EM_LO = 48;
    localparam int EM_HI = 57;
    localparam int EM_ADDR = 0;

    // ----------------------------------------
    // operand exponents and link words
    // ----------------------------------------
    localparam logic [11:0] EXP_INF_P = 12'h3FF;
    localparam logic [11:0] EXP_INF_N = 12'hC00;
    localparam logic [11:0] EXP_IND_P = 12'h1FF;
    localparam logic [11:0] EXP_IND_N = 12'hE00;
    localparam int LINK_POS = 30;
    localparam int COND_POS = 48;

    localparam logic [1:0] KIND_X = 2'h0;
    localparam logic [1:0] KIND_A = 2'h1;
    localparam logic [1:0] KIND_B = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_LOAD     = 3'b001,
        ST_STORE    = 3'b010,
        ST_SWAP_OUT = 3'b011,
        ST_SWAP_IN  = 3'b100,
        ST_EXIT     = 3'b101,
        ST_HALT     = 3'b110
    } crb_state_type;

    typedef struct packed {
        logic [5:0]  fm;
        logic [2:0]  i;
        logic [2:0]  j;
        logic [AW-1:0] kc;
    } crb_inst_type;

    typedef struct packed {
        logic          valid;
        logic [1:0]    kind;
        logic [2:0]    idx;
        logic [XW-1:0] data;
    } crb_result_type;

    typedef struct packed {
        logic          req;
        logic          write;
        logic [BW-1:0] addr;
        logic [XW-1:0] wdata;
    } crb_mem_type;

endpackage : crb_pkg

// >>> crb_regs.sv
`timescale 1ns/100ps
module crb_regs (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // instruction issue
    input  wire logic                    instValid,
    input  wire logic [59:0]             instWord,
    input  wire logic [1:0]              instParcel,
    input  wire logic                    stepDone,
    // execution results and conditions
    input  wire crb_pkg::crb_result_type result,
    input  wire logic                    infOp,
    input  wire logic                    indefOp,
    input  wire logic [2:0]              hwErr,
    input  wire logic                    cmpDone,
    input  wire logic                    cmpEqual,
    // swap control
    input  wire logic                    monitorFlag,
    input  wire logic                    monSwapReq,
    // memory port
    input  wire logic                    memAck,
    input  wire logic [59:0]             memRdata,
    output crb_pkg::crb_mem_type         memOut,
    // register observation
    input  wire logic [1:0]              rdKind,
    input  wire logic [2:0]              rdIdx,
    output logic      [59:0]             rdData,
    // status
    output logic      [17:0]             pc,
    output logic      [20:0]             fetchAddr,
    output logic                         branchTaken,
    output logic                         busy,
    output logic                         halted,
    output logic                         errorExit,
    output logic                         rangeErr,
    output logic      [20:0]             copyCmAddr,
    output logic      [23:0]             copyExtAddr,
    // support registers
    output logic      [20:0]             mainBase,
    output logic      [20:0]             mainLimit,
    output logic      [20:0]             extBase,
    output logic      [23:0]             extLimit,
    output logic      [5:0]              exitSelect,
    output logic      [17:0]             monitorPtr
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [59:0]            xReg [8];
    logic [17:0]            aReg [8];
    logic [17:0]            bReg [8];
    crb_pkg::crb_state_type state;
    crb_pkg::crb_state_type next_state;
    logic [2:0]             swapIdx;
    logic [20:0]            pkgAddr;
    logic [2:0]             target;
    logic [5:0]             condPend;
    logic [59:0]            swapWord;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic [14:0]           parc [4];
    logic [1:0]            secondSel;
    crb_pkg::crb_inst_type inst;
    logic                  take;

    always_comb begin
        for (int n = 0; n < crb_pkg::NPAR; n++) begin
            parc[n] = instWord[59 - n*crb_pkg::PARW -: crb_pkg::PARW];
        end
    end

    assign secondSel = instParcel + 2'h1;
    assign inst.fm   = parc[instParcel][14:9];
    assign inst.i    = parc[instParcel][8:6];
    assign inst.j    = parc[instParcel][5:3];
    assign inst.kc   = {parc[instParcel][2:0], parc[secondSel]};
    assign take      = instValid && (state == crb_pkg::ST_IDLE);

    function automatic logic ocZero(input logic [17:0] v);
        return (v == 18'h00000) || (v == 18'h3FFFF);
    endfunction : ocZero

    // ----------------------------------------
    // branch tests
    // ----------------------------------------
    logic [59:0] xj;
    logic [17:0] bi;
    logic [17:0] bj;
    logic [11:0] xExp;
    logic        xZero;
    logic        xInf;
    logic        xInd;
    logic        bEq;
    logic        bLess;
    logic        cond;
    logic        isRj;
    logic        isXj;
    logic        jump;
    logic [17:0] jumpTarget;

    assign xj    = xReg[inst.j];
    assign bi    = bReg[inst.i];
    assign bj    = bReg[inst.j];
    assign xExp  = xj[59:48];
    assign xZero = (xj == 60'h0) || (xj == {60{1'b1}});
    assign xInf  = (xExp == crb_pkg::EXP_INF_P) || (xExp == crb_pkg::EXP_INF_N);
    assign xInd  = (xExp == crb_pkg::EXP_IND_P) || (xExp == crb_pkg::EXP_IND_N);
    // minus zero counts as plus zero in compares
    assign bEq   = (bi == bj) || (ocZero(bi) && ocZero(bj));
    assign bLess = !bEq && ($signed(bi) < $signed(bj));
    assign isRj  = (inst.fm == crb_pkg::OP_RET) && (inst.i == crb_pkg::SUB_RJ);
    assign isXj  = (inst.fm == crb_pkg::OP_RET) && (inst.i == crb_pkg::SUB_XJ);

    always_comb begin
        cond       = 1'b0;
        jumpTarget = inst.kc;
        case (inst.fm)
            crb_pkg::OP_JMP: begin
                cond       = 1'b1;
                jumpTarget = bi + inst.kc;
            end
            crb_pkg::OP_XBR: begin
                case (inst.i)
                    3'h0:    cond = xZero;
                    3'h1:    cond = !xZero;
                    3'h2:    cond = !xj[59];
                    3'h3:    cond = xj[59];
                    3'h4:    cond = !xInf;
                    3'h5:    cond = xInf;
                    3'h6:    cond = !xInd;
                    default: cond = xInd;
                endcase
            end
            crb_pkg::OP_BEQ: cond = bEq;
            crb_pkg::OP_BNE: cond = !bEq;
            crb_pkg::OP_BGE: cond = !bLess;
            crb_pkg::OP_BLT: cond = bLess;
            crb_pkg::OP_RET: begin
                cond       = isRj;
                jumpTarget = inst.kc + 18'h1;
            end
            default: cond = 1'b0;
        endcase
    end

    assign jump = take && cond;

    // ----------------------------------------
    // address formation and checks
    // ----------------------------------------
    logic        aWrite;
    logic [17:0] relA;
    logic        oor;
    logic        aLoad;
    logic        aStore;
    logic        rangeEvt;
    logic [5:0]  condVec;
    logic        swapGo;
    logic [20:0] swapBase;

    assign aWrite   = result.valid && (result.kind == crb_pkg::KIND_A)
                      && (state == crb_pkg::ST_IDLE);
    assign relA     = result.data[17:0];
    assign oor      = {3'h0, relA} >= mainLimit;
    assign aLoad    = aWrite && !oor && (result.idx >= 3'h1) && (result.idx <= 3'h5);
    assign aStore   = aWrite && !oor && (result.idx >= 3'h6);
    assign rangeEvt = aWrite && oor && (result.idx != 3'h0);
    assign condVec  = {hwErr, indefOp, infOp, rangeEvt};
    assign swapGo   = (take && isXj) || (monSwapReq && !monitorFlag);
    assign swapBase = (take && isXj && !monitorFlag) ? {3'h0, bj + inst.kc}
                                                      : {3'h0, monitorPtr};

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            crb_pkg::ST_IDLE: begin
                if (|condPend) begin
                    next_state = crb_pkg::ST_EXIT;
                end else if (swapGo) begin
                    next_state = crb_pkg::ST_SWAP_IN;
                end else if (take && inst.fm == crb_pkg::OP_STOP) begin
                    next_state = crb_pkg::ST_HALT;
                end else if (aLoad) begin
                    next_state = crb_pkg::ST_LOAD;
                end else if (aStore || (take && isRj)) begin
                    next_state = crb_pkg::ST_STORE;
                end
            end
            crb_pkg::ST_LOAD,
            crb_pkg::ST_STORE: begin
                if (memAck) next_state = crb_pkg::ST_IDLE;
            end
            // read the new word before the old one overwrites it
            crb_pkg::ST_SWAP_IN: begin
                if (memAck) next_state = crb_pkg::ST_SWAP_OUT;
            end
            crb_pkg::ST_SWAP_OUT: begin
                if (memAck) begin
                    next_state = (swapIdx == crb_pkg::PKG_MON) ? crb_pkg::ST_IDLE
                                                               : crb_pkg::ST_SWAP_IN;
                end
            end
            crb_pkg::ST_EXIT: begin
                if (memAck) next_state = crb_pkg::ST_HALT;
            end
            crb_pkg::ST_HALT: begin
                if (monSwapReq && !monitorFlag) next_state = crb_pkg::ST_SWAP_IN;
            end
            default: next_state = crb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state   <= crb_pkg::ST_IDLE;
            busy    <= 1'b0;
            halted  <= 1'b0;
            swapIdx <= 3'h0;
            pkgAddr <= 21'h0;
            target  <= 3'h0;
            swapWord <= 60'h0;
        end else begin
            state  <= next_state;
            busy   <= next_state != crb_pkg::ST_IDLE;
            halted <= next_state == crb_pkg::ST_HALT;
            if (state != crb_pkg::ST_SWAP_IN && next_state == crb_pkg::ST_SWAP_IN
                && state != crb_pkg::ST_SWAP_OUT) begin
                swapIdx <= 3'h0;
                pkgAddr <= (state == crb_pkg::ST_HALT) ? {3'h0, monitorPtr} : swapBase;
            end else if (state == crb_pkg::ST_SWAP_OUT && memAck) begin
                swapIdx <= swapIdx + 3'h1;
            end
            // new word waits here until the old one is out
            if (state == crb_pkg::ST_SWAP_IN && memAck) swapWord <= memRdata;
            if (aWrite) target <= result.idx;
        end
    end

    // ----------------------------------------
    // memory requests
    // ----------------------------------------
    logic [59:0] pkgWord;
    logic [2:0]  outIdx;

    assign outIdx = (state == crb_pkg::ST_SWAP_OUT) ? swapIdx + 3'h1 : 3'h0;

    always_comb begin
        pkgWord = 60'h0;
        case (swapIdx)
            crb_pkg::PKG_P:     pkgWord[17:0] = pc;
            crb_pkg::PKG_BASE:  pkgWord[20:0] = mainBase;
            crb_pkg::PKG_LIM:   pkgWord[20:0] = mainLimit;
            crb_pkg::PKG_EM: begin
                pkgWord[crb_pkg::EM_LO +: 3] = exitSelect[2:0];
                pkgWord[crb_pkg::EM_HI +: 3] = exitSelect[5:3];
            end
            crb_pkg::PKG_EBASE: pkgWord[20:0] = extBase;
            crb_pkg::PKG_ELIM:  pkgWord[23:0] = extLimit;
            crb_pkg::PKG_MON:   pkgWord[17:0] = monitorPtr;
            default:            pkgWord = 60'h0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            memOut <= '0;
        end else if (next_state != state) begin
            memOut.req <= 1'b1;
            case (next_state)
                crb_pkg::ST_LOAD: begin
                    memOut.write <= 1'b0;
                    memOut.addr  <= mainBase + {3'h0, relA};
                end
                crb_pkg::ST_STORE: begin
                    memOut.write <= 1'b1;
                    memOut.addr  <= mainBase + {3'h0, aStore ? relA : inst.kc};
                    memOut.wdata <= aStore ? xReg[result.idx]
                                           : {42'h0, pc + 18'h1} << crb_pkg::LINK_POS;
                end
                crb_pkg::ST_SWAP_IN: begin
                    memOut.write <= 1'b0;
                    memOut.addr  <= (state == crb_pkg::ST_SWAP_OUT) ? pkgAddr + {18'h0, outIdx}
                                                                    : swapBase;
                end
                crb_pkg::ST_SWAP_OUT: begin
                    memOut.write <= 1'b1;
                    memOut.wdata <= pkgWord;
                end
                crb_pkg::ST_EXIT: begin
                    memOut.write <= 1'b1;
                    memOut.addr  <= mainBase;
                    memOut.wdata <= {condPend, 36'h0, pc};
                end
                default: memOut.req <= 1'b0;
            endcase
        end else if (memAck) begin
            memOut.req <= 1'b0;
        end
    end

    // ----------------------------------------
    // support registers
    // ----------------------------------------
    logic loadWord;

    assign loadWord = (state == crb_pkg::ST_SWAP_OUT) && memAck;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mainBase   <= 21'h0;
            mainLimit  <= 21'h0;
            extBase    <= 21'h0;
            extLimit   <= 24'h0;
            exitSelect <= 6'h0;
            monitorPtr <= 18'h0;
        end else if (loadWord) begin
            case (swapIdx)
                crb_pkg::PKG_BASE: mainBase <= swapWord[20:0];
                crb_pkg::PKG_LIM:  mainLimit <= swapWord[20:0];
                crb_pkg::PKG_EM: begin
                    exitSelect <= {swapWord[crb_pkg::EM_HI +: 3], swapWord[crb_pkg::EM_LO +: 3]};
                end
                crb_pkg::PKG_EBASE: extBase <= {swapWord[20:crb_pkg::EZB], 6'h0};
                crb_pkg::PKG_ELIM:  extLimit <= {swapWord[23:crb_pkg::EZB], 6'h0};
                crb_pkg::PKG_MON:   monitorPtr <= swapWord[17:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // program counter
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pc          <= 18'h0;
            fetchAddr   <= 21'h0;
            branchTaken <= 1'b0;
        end else begin
            branchTaken <= jump;
            if (loadWord && swapIdx == crb_pkg::PKG_P) begin
                pc <= swapWord[17:0];
            end else if (jump) begin
                pc <= jumpTarget;
            end else if (stepDone && state == crb_pkg::ST_IDLE) begin
                pc <= pc + 18'h1;
            end
            fetchAddr <= mainBase + {3'h0, pc};
        end
    end

    // ----------------------------------------
    // exit handling
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            condPend  <= 6'h0;
            errorExit <= 1'b0;
            rangeErr  <= 1'b0;
        end else begin
            rangeErr  <= rangeEvt;
            errorExit <= (state == crb_pkg::ST_IDLE) && (next_state == crb_pkg::ST_EXIT);
            // only selected conditions; new ones survive the clear
            condPend  <= (next_state == crb_pkg::ST_EXIT ? 6'h0 : condPend)
                         | (condVec & exitSelect);
        end
    end

    // ----------------------------------------
    // operating registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < 8; n++) xReg[n] <= 60'h0;
        end else if (state == crb_pkg::ST_LOAD && memAck) begin
            xReg[target] <= memRdata;
        end else if (result.valid && result.kind == crb_pkg::KIND_X
                     && state == crb_pkg::ST_IDLE) begin
            xReg[result.idx] <= result.data;
        end else if (cmpDone) begin
            xReg[0] <= {59'h0, cmpEqual};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < 8; n++) aReg[n] <= 18'h0;
        end else if (aWrite) begin
            aReg[result.idx] <= relA;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int n = 0; n < 8; n++) bReg[n] <= 18'h0;
        end else if (result.valid && result.kind == crb_pkg::KIND_B
                     && state == crb_pkg::ST_IDLE && result.idx != 3'h0) begin
            bReg[result.idx] <= result.data[17:0];
        end
    end

    // ----------------------------------------
    // observation and copy addresses
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdData      <= 60'h0;
            copyCmAddr  <= 21'h0;
            copyExtAddr <= 24'h0;
        end else begin
            case (rdKind)
                crb_pkg::KIND_X: rdData <= xReg[rdIdx];
                crb_pkg::KIND_A: rdData <= {42'h0, aReg[rdIdx]};
                crb_pkg::KIND_B: rdData <= {42'h0, bReg[rdIdx]};
                default:         rdData <= 60'h0;
            endcase
            copyCmAddr  <= mainBase + {3'h0, aReg[0]};
            copyExtAddr <= {3'h0, extBase} + xReg[0][23:0];
        end
    end

endmodule : crb_regs

// >>> crb_regs_monitor.sv
`timescale 1ns/100ps
module crb_regs_monitor (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // memory port
    input wire logic                 memAck,
    input wire crb_pkg::crb_mem_type memOut,
    // status
    input wire logic [17:0]          pc,
    input wire logic [20:0]          fetchAddr,
    input wire logic                 branchTaken,
    input wire logic                 busy,
    input wire logic                 halted,
    input wire logic                 errorExit,
    input wire logic                 rangeErr,
    // support registers
    input wire logic [20:0]          mainBase,
    input wire logic [20:0]          mainLimit,
    input wire logic [20:0]          extBase,
    input wire logic [23:0]          extLimit,
    input wire logic [5:0]           exitSelect,
    input wire logic [17:0]          monitorPtr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_req_held: assert property (
        memOut.req && !memAck |=> memOut.req && $stable(memOut.addr)) else $error("request dropped early");
    chk_req_drop: assert property (
        memOut.req && memAck |=> !memOut.req || $changed(memOut.write)) else $error("request held after ack");
    chk_fetch_base: assert property (
        !$past(rst) |-> fetchAddr == 21'($past(mainBase) + 21'($past(pc)))) else $error("fetch address not base plus pc");
    chk_ext_zero: assert property (
        extBase[5:0] == 6'h00 && extLimit[5:0] == 6'h00) else $error("extended low bits set");
    chk_supp_stable: assert property (
        !$past(busy) && !$past(rst) |-> $stable({mainBase, mainLimit, extBase, extLimit, exitSelect, monitorPtr}))
        else $error("support register changed outside swap");
    chk_exit_halt: assert property (
        errorExit |-> ##[1:100] halted) else $error("error exit did not halt");
    chk_range_noacc: assert property (
        rangeErr |-> !memOut.req) else $error("access issued out of range");
    chk_req_busy: assert property (
        memOut.req |-> busy) else $error("request while idle");
    cover property (branchTaken);
    cover property (rangeErr);
    cover property (errorExit);
endmodule : crb_regs_monitor
bind crb_regs crb_regs_monitor crb_regs_monitor_i (.ref_clk(ref_clk), .rst(rst), .memAck(memAck), .memOut(memOut),
    .pc(pc), .fetchAddr(fetchAddr), .branchTaken(branchTaken), .busy(busy), .halted(halted), .errorExit(errorExit),
    .rangeErr(rangeErr), .mainBase(mainBase), .mainLimit(mainLimit), .extBase(extBase), .extLimit(extLimit),
    .exitSelect(exitSelect), .monitorPtr(monitorPtr));

// >>> crb_mem_model.sv
`timescale 1ns/100ps
module crb_mem_model #(parameter int LAT = 2) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire crb_pkg::crb_mem_type memOut,
    output logic                      memAck,
    output logic [59:0]               memRdata
);
    logic [59:0] mem [0:1023];
    int          cnt;
    // read data toggles off the ack cycle so stale words never look valid
    always @(posedge ref_clk) begin
        memAck <= 1'b0;
        memRdata <= rst ? 60'h0 : ~memRdata;
        if (rst) cnt <= 0;
        else if (memOut.req && !memAck) begin
            cnt <= (cnt == LAT) ? 0 : cnt + 1;
            if (cnt == LAT) begin
                memAck <= 1'b1;
                if (memOut.write) mem[memOut.addr[9:0]] <= memOut.wdata;
                else memRdata <= mem[memOut.addr[9:0]];
            end
        end
    end
endmodule : crb_mem_model

// >>> crb_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module crb_regs_tb;
    logic ref_clk = 0, rst = 1, instValid = 0, stepDone = 0, cmpDone = 0, cmpEqual = 0, monSwapReq = 0, memAck;
    logic [59:0] instWord = 60'h0, memRdata, rdData, d;
    logic [1:0] rdKind = 2'h0, instParcel = 2'h0;
    logic [2:0] rdIdx = 3'h0;
    logic [17:0] pc, ep;
    logic [20:0] fetchAddr, copyCmAddr, mainBase, mainLimit, extBase;
    logic [23:0] copyExtAddr, extLimit;
    logic [5:0] exitSelect;
    logic [17:0] monitorPtr;
    logic branchTaken, busy, halted, errorExit, rangeErr;
    crb_pkg::crb_result_type result = '0;
    crb_pkg::crb_mem_type memOut;
    int bad_count = 0, checks_done = 0, cycles = 0;
    crb_regs crb_regs_i (.ref_clk(ref_clk), .rst(rst), .instValid(instValid), .instWord(instWord),
        .instParcel(instParcel), .stepDone(stepDone), .result(result), .infOp(1'b0), .indefOp(1'b0), .hwErr(3'h0),
        .cmpDone(cmpDone), .cmpEqual(cmpEqual), .monitorFlag(1'b0), .monSwapReq(monSwapReq), .memAck(memAck),
        .memRdata(memRdata), .memOut(memOut), .rdKind(rdKind), .rdIdx(rdIdx), .rdData(rdData), .pc(pc),
        .fetchAddr(fetchAddr), .branchTaken(branchTaken), .busy(busy), .halted(halted), .errorExit(errorExit),
        .rangeErr(rangeErr), .copyCmAddr(copyCmAddr), .copyExtAddr(copyExtAddr), .mainBase(mainBase),
        .mainLimit(mainLimit), .extBase(extBase), .extLimit(extLimit), .exitSelect(exitSelect),
        .monitorPtr(monitorPtr));
    crb_mem_model crb_mem_model_i (.ref_clk(ref_clk), .rst(rst), .memOut(memOut), .memAck(memAck),
        .memRdata(memRdata));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    task automatic idle();
        repeat (300) if (busy) tick(1);
    endtask : idle
    task automatic issue(input logic [5:0] fm, input logic [2:0] i, input logic [2:0] j, input logic [17:0] k);
        instWord = {fm, i, j, k, 30'h0} >> (15 * instParcel);
        instValid = 1'b1;
        tick(1);
        instValid = 1'b0;
    endtask : issue
    task automatic wr(input logic [1:0] kind, input logic [2:0] idx, input logic [59:0] v);
        result = '{1'b1, kind, idx, v};
        tick(1);
        result.valid = 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] kind, input logic [2:0] idx);
        rdKind = kind;
        rdIdx = idx;
        tick(2);
        d = rdData;
    endtask : rd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial begin
        crb_mem_model_i.mem[0] = 60'h10;
        crb_mem_model_i.mem[1] = 60'h200;
        crb_mem_model_i.mem[2] = 60'h40;
        crb_mem_model_i.mem[3] = 60'h801000000000000;
        crb_mem_model_i.mem[4] = 60'hABC;
        crb_mem_model_i.mem[5] = 60'h1234;
        crb_mem_model_i.mem[6] = 60'h0;
        crb_mem_model_i.mem[10'h208] = 60'hCAFE;
        tick(8);
        rst = 1'b0;
        `CHK({pc, mainBase, mainLimit, exitSelect}, 66'h0)
        monSwapReq = 1'b1;
        tick(1);
        monSwapReq = 1'b0;
        idle();
        `CHK({pc, mainBase, mainLimit}, {18'h10, 21'h200, 21'h40})
        `CHK({exitSelect, extBase, extLimit, monitorPtr}, {6'h21, 21'hA80, 24'h1200, 18'h0})
        $display("test swap done");
        issue(crb_pkg::OP_JMP, 3'h0, 3'h0, 18'h123);
        `CHK({pc, branchTaken}, {18'h123, 1'b1})
        wr(crb_pkg::KIND_B, 3'h2, 60'h5);
        instParcel = 2'h2;
        issue(crb_pkg::OP_JMP, 3'h2, 3'h0, 18'h100);
        `CHK(pc, 18'h105)
        instParcel = 2'h0;
        wr(crb_pkg::KIND_B, 3'h0, 60'h7);
        rd(crb_pkg::KIND_B, 3'h0);
        `CHK(d, 60'h0)
        wr(crb_pkg::KIND_B, 3'h1, 60'h5);
        tick(1);
        wr(crb_pkg::KIND_B, 3'h2, 60'h3);
        ep = pc;
        for (int op = 4; op < 8; op++) begin
            issue(6'(op), 3'h1, 3'h2, 18'(op + 32));
            if (op == 5 || op == 6) ep = 18'(op + 32);
            `CHK(pc, ep)
            tick(1);
        end
        wr(crb_pkg::KIND_X, 3'h1, 60'h0);
        for (int i = 0; i < 8; i++) begin
            issue(crb_pkg::OP_XBR, 3'(i), 3'h1, 18'(i + 64));
            if (i % 2 == 0) ep = 18'(i + 64);
            `CHK(pc, ep)
            tick(1);
        end
        $display("test branches done");
        wr(crb_pkg::KIND_A, 3'h1, 60'h8);
        idle();
        rd(crb_pkg::KIND_X, 3'h1);
        `CHK(d, 60'hCAFE)
        wr(crb_pkg::KIND_X, 3'h6, 60'h5A5);
        tick(1);
        wr(crb_pkg::KIND_A, 3'h6, 60'h9);
        idle();
        `CHK(crb_mem_model_i.mem[10'h209], 60'h5A5)
        cmpEqual = 1'b1;
        cmpDone = 1'b1;
        stepDone = 1'b1;
        tick(1);
        cmpDone = 1'b0;
        stepDone = 1'b0;
        `CHK(pc, ep + 18'h1)
        rd(crb_pkg::KIND_X, 3'h0);
        `CHK(d, 60'h1)
        `CHK({copyCmAddr, copyExtAddr}, {21'h200, 24'hA81})
        ep = pc;
        issue(crb_pkg::OP_RET, crb_pkg::SUB_RJ, 3'h0, 18'h30);
        idle();
        `CHK(pc, 18'h31)
        `CHK(crb_mem_model_i.mem[10'h230], 60'(ep + 18'h1) << 30)
        $display("test memory done");
        ep = pc;
        wr(crb_pkg::KIND_A, 3'h1, 60'h40);
        `CHK({rangeErr, memOut.req}, 2'b10)
        tick(1);
        `CHK(errorExit, 1'b1)
        repeat (100) if (!halted) tick(1);
        `CHK(halted, 1'b1)
        `CHK(crb_mem_model_i.mem[10'h200], {6'h01, 36'h0, ep})
        $display("test error exit done");
        finish_test();
    end
endmodule : crb_regs_tb
